// *** design/tpr_router.sv ***
// transaction router: packet steering, transmit arbitration, local registers
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "tpr_map.svh"
module tpr_router #(
  parameter bit FMT_RAW = 1'b0,
  parameter bit IO_INIT_TGT = 1'b0,
  parameter bit MSG_ON_IO = 1'b0,
  parameter bit MAINT_EN = 1'b1,
  parameter bit USER_EN = 1'b1,
  parameter bit MAINT_STREAM = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cfg_rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ucfg_valid,
  input wire logic ucfg_wr,
  input wire logic [11:0] ucfg_addr,
  input wire logic [31:0] ucfg_wdata,
  output logic ucfg_ready,
  output logic ucfg_rvalid,
  output logic [31:0] ucfg_rdata,
  output logic link_cfg_wr,
  output logic link_cfg_rd,
  output logic [7:0] link_cfg_addr,
  output logic [31:0] link_cfg_wdata,
  input wire logic [31:0] link_cfg_rdata,
  output logic buf_cfg_wr,
  output logic buf_cfg_rd,
  output logic [7:0] buf_cfg_addr,
  output logic [31:0] buf_cfg_wdata,
  input wire logic [31:0] buf_cfg_rdata,
  input wire logic trn_rx_tvalid,
  output logic trn_rx_tready,
  input wire logic [63:0] trn_rx_tdata,
  input wire logic [7:0] trn_rx_tkeep,
  input wire logic trn_rx_tlast,
  input wire logic [31:0] trn_rx_tuser,
  output logic trn_tx_tvalid,
  input wire logic trn_tx_tready,
  output logic [63:0] trn_tx_tdata,
  output logic [7:0] trn_tx_tkeep,
  output logic trn_tx_tlast,
  output logic [31:0] trn_tx_tuser,
  output logic [4:0] urx_tvalid,
  input wire logic [4:0] urx_tready,
  output logic [63:0] urx_tdata,
  output logic [7:0] urx_tkeep,
  output logic urx_tlast,
  output logic [31:0] urx_tuser,
  input wire logic [3:0] utx_tvalid,
  output logic [3:0] utx_tready,
  input wire logic [255:0] utx_tdata,
  input wire logic [31:0] utx_tkeep,
  input wire logic [3:0] utx_tlast,
  input wire logic [127:0] utx_tuser
);
  // transmit sources: 0 I/O, 1 messaging, 2 maintenance, 3 user-defined
  localparam logic [3:0] TX_EN_MASK = {USER_EN, MAINT_EN, !MSG_ON_IO, 1'b1};

  tpr_pkg::tpr_state_t s;
  tpr_pkg::tpr_state_t n;
  tpr_cfg_if cfg ();
  logic [3:0] ft;
  tpr_pkg::tpr_dst_t dst_now;
  logic [7:0] rdy8;
  logic out_free;
  logic rx_beat;
  logic sof;
  logic drop_inc;
  logic drop_clr;
  logic [3:0] tx_req;
  logic tx_free;
  logic tx_beat;
  logic reg_go;
  logic ucfg_go;

  // ****************************************
  // configuration master and fabric
  // ****************************************
  // software bus never waits, so the user request yields to it
  assign ucfg_ready = !MAINT_STREAM && !(reg_wr || reg_rd);
  assign reg_go = reg_wr || reg_rd;
  assign ucfg_go = ucfg_valid && ucfg_ready;
  assign cfg.wr = reg_wr || (ucfg_go && ucfg_wr);
  assign cfg.rd = reg_rd || (ucfg_go && !ucfg_wr);
  assign cfg.addr = reg_go ? reg_addr : ucfg_addr;
  assign cfg.wdata = reg_go ? reg_wdata : ucfg_wdata;
  assign cfg.loc_rdata = s.loc_rdata;
  assign reg_rdata = cfg.rdata;
  assign ucfg_rdata = cfg.rdata;
  assign ucfg_rvalid = s.ucfg_rp;

  tpr_cfg_fabric u_fabric (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cfg(cfg.fab),
    .link_cfg_wr(link_cfg_wr),
    .link_cfg_rd(link_cfg_rd),
    .link_cfg_addr(link_cfg_addr),
    .link_cfg_wdata(link_cfg_wdata),
    .link_cfg_rdata(link_cfg_rdata),
    .buf_cfg_wr(buf_cfg_wr),
    .buf_cfg_rd(buf_cfg_rd),
    .buf_cfg_addr(buf_cfg_addr),
    .buf_cfg_wdata(buf_cfg_wdata),
    .buf_cfg_rdata(buf_cfg_rdata)
  );

  function automatic logic [31:0] loc_read(input logic [7:0] a, input tpr_pkg::tpr_state_t st);
    logic [31:0] v;
    case (a)
      `TPR_OFF_CTRL: v = {30'h0, st.ctrl};
      `TPR_OFF_STATUS: v = {24'h0, MAINT_STREAM, USER_EN, MAINT_EN, MSG_ON_IO, IO_INIT_TGT,
        FMT_RAW, st.tx_st == tpr_pkg::TX_LOCK || st.tv, st.rx_st == tpr_pkg::RX_MID || st.ov};
      `TPR_OFF_DROPS: v = {16'h0, st.drops};
      `TPR_OFF_DEVID: v = {16'h0, st.devid};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ****************************************
  // receive classification
  // ****************************************
  function automatic tpr_pkg::tpr_dst_t classify(input logic [3:0] f);
    tpr_pkg::tpr_dst_t d;
    case (f)
      `TPR_FT_NREAD, `TPR_FT_NWRITE, `TPR_FT_SWRITE: d = tpr_pkg::D_IO;
      `TPR_FT_DBELL: d = tpr_pkg::D_IO;
      `TPR_FT_RESP: d = IO_INIT_TGT ? tpr_pkg::D_INI : tpr_pkg::D_IO;
      `TPR_FT_MAINT: d = MAINT_EN ? tpr_pkg::D_MNT : tpr_pkg::D_USR;
      `TPR_FT_MSG: d = MSG_ON_IO ? tpr_pkg::D_IO : tpr_pkg::D_MSG;
      default: d = tpr_pkg::D_USR;
    endcase
    if (d == tpr_pkg::D_USR && !USER_EN) begin
      d = tpr_pkg::D_DROP;
    end
    return d;
  endfunction

  // field position is fixed by the generation-time format
  assign ft = FMT_RAW ? trn_rx_tdata[`TPR_RAW_FT_LSB +: 4] : trn_rx_tdata[`TPR_HDR_FT_LSB +: 4];
  assign sof = s.rx_st == tpr_pkg::RX_SOF;
  assign dst_now = sof ? classify(ft) : s.rx_dst;
  assign rdy8 = {3'h0, urx_tready};
  assign out_free = !s.ov || rdy8[s.od_dst];
  // drop beats never wait on the output stage
  assign trn_rx_tready = s.ctrl[`TPR_CTRL_RX_EN] && (dst_now == tpr_pkg::D_DROP || out_free);
  assign rx_beat = trn_rx_tvalid && trn_rx_tready;
  assign drop_inc = rx_beat && sof && dst_now == tpr_pkg::D_DROP;
  assign drop_clr = cfg.loc_wr && cfg.addr[7:0] == `TPR_OFF_DROPS;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_rx
      assign urx_tvalid[gi] = s.ov && s.od_dst == tpr_pkg::tpr_dst_t'(gi);
    end
    for (gi = 0; gi < 4; gi++) begin : g_tx
      assign utx_tready[gi] = s.tx_st == tpr_pkg::TX_LOCK && s.tx_src == 2'(gi) && tx_free;
    end
  endgenerate
  assign urx_tdata = s.od;
  assign urx_tkeep = s.ok;
  assign urx_tlast = s.ol;
  assign urx_tuser = s.ou;

  // ****************************************
  // transmit arbitration
  // ****************************************
  // fixed priority, held for a whole packet; a busy I/O source can starve others
  function automatic logic [1:0] pick(input logic [3:0] r);
    logic [1:0] p;
    p = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (r[i]) begin
        p = 2'(i);
      end
    end
    return p;
  endfunction

  assign tx_req = utx_tvalid & TX_EN_MASK;
  assign tx_free = !s.tv || trn_tx_tready;
  assign tx_beat = |(utx_tvalid & utx_tready);
  assign trn_tx_tvalid = s.tv;
  assign trn_tx_tdata = s.td;
  assign trn_tx_tkeep = s.tk;
  assign trn_tx_tlast = s.tl;
  assign trn_tx_tuser = s.tu;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    n.ucfg_rp = ucfg_go && !ucfg_wr;
    if (cfg.loc_rd) begin
      n.loc_rdata = loc_read(cfg.addr[7:0], s);
    end
    if (cfg.loc_wr && cfg.addr[7:0] == `TPR_OFF_CTRL) begin
      n.ctrl = cfg.wdata[1:0];
    end
    if (cfg.loc_wr && cfg.addr[7:0] == `TPR_OFF_DEVID) begin
      n.devid = cfg.wdata[15:0];
    end
    // a drop in the clearing cycle is still counted
    n.drops = drop_clr ? {15'h0, drop_inc} : s.drops + {15'h0, drop_inc};
    if (!cfg_rst_n) begin
      n.ctrl = `TPR_CTRL_RST;
      n.devid = `TPR_DEVID_RST;
      n.drops = 16'h0000;
    end
    if (s.ov && rdy8[s.od_dst]) begin
      n.ov = 1'b0;
    end
    case (s.rx_st)
      tpr_pkg::RX_SOF, tpr_pkg::RX_MID: begin
        if (rx_beat) begin
          n.rx_dst = dst_now;
          n.rx_st = trn_rx_tlast ? tpr_pkg::RX_SOF : tpr_pkg::RX_MID;
          if (dst_now != tpr_pkg::D_DROP) begin
            n.ov = 1'b1;
            n.od_dst = dst_now;
            n.od = trn_rx_tdata;
            n.ok = FMT_RAW ? trn_rx_tkeep : `TPR_KEEP_ALL;
            n.ol = trn_rx_tlast;
            n.ou = trn_rx_tuser;
          end
        end
      end
      default: n.rx_st = tpr_pkg::RX_SOF;
    endcase
    if (s.tv && trn_tx_tready) begin
      n.tv = 1'b0;
    end
    case (s.tx_st)
      tpr_pkg::TX_IDLE: begin
        if (s.ctrl[`TPR_CTRL_TX_EN] && |tx_req) begin
          n.tx_st = tpr_pkg::TX_LOCK;
          n.tx_src = pick(tx_req);
        end
      end
      tpr_pkg::TX_LOCK: begin
        if (tx_beat) begin
          n.tv = 1'b1;
          n.td = utx_tdata[{s.tx_src, 6'h0} +: 64];
          n.tk = FMT_RAW ? utx_tkeep[{s.tx_src, 3'h0} +: 8] : `TPR_KEEP_ALL;
          n.tl = utx_tlast[s.tx_src];
          n.tu = utx_tuser[{s.tx_src, 5'h0} +: 32];
          if (!FMT_RAW) begin
            n.tu[31:16] = s.devid;
          end
          if (utx_tlast[s.tx_src]) begin
            n.tx_st = tpr_pkg::TX_IDLE;
          end
        end
      end
      default: n.tx_st = tpr_pkg::TX_IDLE;
    endcase
  end

  // one core_clk at a fixed rate whatever the trained lane width
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.rx_st <= tpr_pkg::RX_SOF;
      s.tx_st <= tpr_pkg::TX_IDLE;
      s.ctrl <= `TPR_CTRL_RST;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  io_route_a: assert property (
    rx_beat && sof && ft == `TPR_FT_NWRITE |=> s.ov && s.od_dst == tpr_pkg::D_IO)
    else $error("write not sent to I/O port");
  msg_route_a: assert property (
    rx_beat && sof && ft == `TPR_FT_MSG
    |=> s.od_dst == (MSG_ON_IO ? tpr_pkg::D_IO : tpr_pkg::D_MSG))
    else $error("message misrouted");
  bell_route_a: assert property (
    rx_beat && sof && ft == `TPR_FT_DBELL |=> s.od_dst == tpr_pkg::D_IO)
    else $error("doorbell not on I/O port");
  maint_route_a: assert property (
    MAINT_EN && rx_beat && sof && ft == `TPR_FT_MAINT |=> s.od_dst == tpr_pkg::D_MNT)
    else $error("maintenance not on its port");
  user_route_a: assert property (
    USER_EN && rx_beat && sof && ft == 4'h0 |=> s.ov && s.od_dst == tpr_pkg::D_USR)
    else $error("unknown type not on user port");
  drop_count_a: assert property (
    drop_inc && !drop_clr && cfg_rst_n |=> s.drops == $past(s.drops) + 16'h0001)
    else $error("drop not counted");
  drop_flow_a: assert property (
    trn_rx_tvalid && s.ctrl[0] && dst_now == tpr_pkg::D_DROP |-> trn_rx_tready ##1 !$rose(s.ov))
    else $error("dropped beat stalled or forwarded");
  cfg_reset_a: assert property (
    !cfg_rst_n |=> s.ctrl == `TPR_CTRL_RST && s.drops == 16'h0000 && s.devid == 16'h0000)
    else $error("register reset ignored");
  no_master_a: assert property (
    MAINT_STREAM |-> !ucfg_ready ##1 !ucfg_rvalid)
    else $error("configuration master present in stream mode");
  loc_read_a: assert property (
    reg_rd && reg_addr == 12'h00c |=> reg_rdata == {16'h0000, $past(s.devid)})
    else $error("local register read wrong");
  ucfg_read_a: assert property (
    ucfg_go && !ucfg_wr ##1 !(ucfg_go && !ucfg_wr) |-> ucfg_rvalid ##1 !ucfg_rvalid)
    else $error("user read answer missing");
  tx_hold_a: assert property (
    s.tv && !trn_tx_tready |=> s.tv && $stable(s.td) && $stable(s.tl))
    else $error("transmit beat changed while stalled");
  keep_fmt_a: assert property (
    !FMT_RAW && s.ov |-> urx_tkeep == `TPR_KEEP_ALL)
    else $error("header format keep not full");
  drop_cov: cover property (drop_inc ##1 rx_beat);
  msg_cov: cover property (urx_tvalid[2] && urx_tready[2] && urx_tlast);
  tx_cov: cover property (s.tv && trn_tx_tready && s.tl ##1 s.tx_st == tpr_pkg::TX_LOCK);
  lnk_cov: cover property (link_cfg_rd ##1 reg_rdata != 32'h0000_0000);
endmodule

// *** include/tpr_map.svh ***
// register offsets, field positions and reset values of the transaction router
`ifndef TPR_MAP_SVH
`define TPR_MAP_SVH

// ****************************************
// configuration windows
// ****************************************
`define TPR_WIN_LOCAL 2'h0
`define TPR_WIN_LINK 2'h1
`define TPR_WIN_BUF 2'h2
`define TPR_WIN_NONE 2'h3

// ****************************************
// local registers
// ****************************************
`define TPR_OFF_CTRL 8'h00
`define TPR_OFF_STATUS 8'h04
`define TPR_OFF_DROPS 8'h08
`define TPR_OFF_DEVID 8'h0c
`define TPR_CTRL_RX_EN 0
`define TPR_CTRL_TX_EN 1
`define TPR_CTRL_RST 2'h3
`define TPR_DEVID_RST 16'h0000

// ****************************************
// packet fields
// ****************************************
`define TPR_HDR_FT_LSB 52
`define TPR_RAW_FT_LSB 44
`define TPR_FT_NREAD 4'h2
`define TPR_FT_NWRITE 4'h5
`define TPR_FT_SWRITE 4'h6
`define TPR_FT_MAINT 4'h8
`define TPR_FT_DBELL 4'ha
`define TPR_FT_MSG 4'hb
`define TPR_FT_RESP 4'hd
`define TPR_KEEP_ALL 8'hff
`endif

// *** include/tpr_pkg.sv ***
// types shared by the transaction router and its configuration fabric
package tpr_pkg;
  typedef enum logic [1:0] {RX_SOF = 2'b01, RX_MID = 2'b10} tpr_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_LOCK = 2'b10} tpr_tx_st_t;
  typedef enum logic [2:0] {
    D_IO = 3'h0, D_INI = 3'h1, D_MSG = 3'h2, D_MNT = 3'h3, D_USR = 3'h4, D_DROP = 3'h5
  } tpr_dst_t;
  typedef struct packed {
    logic [1:0] ctrl;
    logic [15:0] devid;
    logic [15:0] drops;
    logic [31:0] loc_rdata;
    logic ucfg_rp;
    tpr_rx_st_t rx_st;
    tpr_dst_t rx_dst;
    logic ov;
    tpr_dst_t od_dst;
    logic [63:0] od;
    logic [7:0] ok;
    logic ol;
    logic [31:0] ou;
    tpr_tx_st_t tx_st;
    logic [1:0] tx_src;
    logic tv;
    logic [63:0] td;
    logic [7:0] tk;
    logic tl;
    logic [31:0] tu;
  } tpr_state_t;
  typedef struct packed {
    logic [1:0] sel;
  } tpr_fab_t;
endpackage

// *** include/tpr_cfg_if.sv ***
// configuration master to fabric carrier
`timescale 1ns/1ps
interface tpr_cfg_if;
  logic wr;
  logic rd;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic loc_wr;
  logic loc_rd;
  logic [31:0] loc_rdata;
  modport mst (output wr, rd, addr, wdata, loc_rdata, input rdata, loc_wr, loc_rd);
  modport fab (input wr, rd, addr, wdata, loc_rdata, output rdata, loc_wr, loc_rd);
endinterface

// *** design/tpr_cfg_fabric.sv ***
// configuration fabric: address decode to local, link layer and buffer ports
`timescale 1ns/1ps
`include "tpr_map.svh"
module tpr_cfg_fabric (
  input wire logic core_clk,
  input wire logic rst_n,
  tpr_cfg_if.fab cfg,
  output logic link_cfg_wr,
  output logic link_cfg_rd,
  output logic [7:0] link_cfg_addr,
  output logic [31:0] link_cfg_wdata,
  input wire logic [31:0] link_cfg_rdata,
  output logic buf_cfg_wr,
  output logic buf_cfg_rd,
  output logic [7:0] buf_cfg_addr,
  output logic [31:0] buf_cfg_wdata,
  input wire logic [31:0] buf_cfg_rdata
);
  tpr_pkg::tpr_fab_t s;
  tpr_pkg::tpr_fab_t n;
  logic [1:0] win;

  // upper address bits outside every window count as unmapped
  assign win = (|cfg.addr[11:10]) ? `TPR_WIN_NONE : cfg.addr[9:8];
  assign cfg.loc_wr = cfg.wr && win == `TPR_WIN_LOCAL;
  assign cfg.loc_rd = cfg.rd && win == `TPR_WIN_LOCAL;
  assign link_cfg_wr = cfg.wr && win == `TPR_WIN_LINK;
  assign link_cfg_rd = cfg.rd && win == `TPR_WIN_LINK;
  assign buf_cfg_wr = cfg.wr && win == `TPR_WIN_BUF;
  assign buf_cfg_rd = cfg.rd && win == `TPR_WIN_BUF;
  // forwarded unregistered so targets answer in the next cycle
  assign link_cfg_addr = cfg.addr[7:0];
  assign link_cfg_wdata = cfg.wdata;
  assign buf_cfg_addr = cfg.addr[7:0];
  assign buf_cfg_wdata = cfg.wdata;

  always_comb begin
    n = s;
    if (cfg.rd) begin
      n.sel = win;
    end
  end

  always_comb begin
    case (s.sel)
      `TPR_WIN_LOCAL: cfg.rdata = cfg.loc_rdata;
      `TPR_WIN_LINK: cfg.rdata = link_cfg_rdata;
      `TPR_WIN_BUF: cfg.rdata = buf_cfg_rdata;
      default: cfg.rdata = 32'h0000_0000;
    endcase
  end

  // cfg side shares core_clk, so no crossing is needed
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  link_read_a: assert property (
    cfg.rd && cfg.addr[11:8] == 4'h1 |=> cfg.rdata == link_cfg_rdata)
    else $error("link window read not returned");
  unmapped_a: assert property (
    cfg.rd && |cfg.addr[11:10] |=> cfg.rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

// *** dv/tpr_link_model.sv ***
// link-side partner: receive source, transmit sink, link and buffer register targets
`timescale 1ns/1ps
module tpr_link_model (
  input wire logic core_clk,
  output logic rx_tvalid,
  input wire logic rx_tready,
  output logic [63:0] rx_tdata,
  output logic rx_tlast,
  output logic tx_tready,
  input wire logic [1:0] cfg_wr,
  input wire logic [1:0] cfg_rd,
  input wire logic [15:0] cfg_addr,
  input wire logic [63:0] cfg_wdata,
  output logic [63:0] cfg_rdata
);
  logic [64:0] q[$];
  logic [31:0] mem[2][256];
  initial begin
    rx_tvalid = 1'h0;
    rx_tdata = 64'h0;
    rx_tlast = 1'h0;
    tx_tready = 1'h0;
    cfg_rdata = 64'h0;
  end
  task automatic push(input logic [63:0] d, input logic l);
    q.push_back({l, d});
  endtask
  // ****************************************
  // stream sides
  // ****************************************
  // an offered beat is held until taken; idle lines toggle so stale data never looks valid
  always @(posedge core_clk) begin
    tx_tready <= $urandom_range(3) != 0;
    if (!(rx_tvalid && !rx_tready)) begin
      if (rx_tvalid) void'(q.pop_front());
      if (q.size() != 0 && $urandom_range(3) != 0) begin
        rx_tvalid <= 1'h1;
        {rx_tlast, rx_tdata} <= q[0];
      end else begin
        rx_tvalid <= 1'h0;
        {rx_tlast, rx_tdata} <= ~{rx_tlast, rx_tdata};
      end
    end
  end
  // ****************************************
  // register targets
  // ****************************************
  // read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (cfg_wr[i]) mem[i][cfg_addr[8*i+:8]] <= cfg_wdata[32*i+:32];
      cfg_rdata[32*i+:32] <= cfg_rd[i] ? mem[i][cfg_addr[8*i+:8]] : ~cfg_rdata[32*i+:32];
    end
  end
endmodule

// *** dv/transaction_port_router_bench.sv ***
// randomised self-checking bench of the transaction router
`timescale 1ns/1ps
`include "tpr_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module transaction_port_router_bench;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic cfg_rst_n = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic ucfg_valid = 1'h0;
  logic ucfg_wr = 1'h0;
  logic [11:0] ucfg_addr = 12'h0;
  logic [31:0] ucfg_wdata = 32'h0;
  logic [4:0] urx_tready = 5'h1f;
  logic [3:0] utx_tvalid = 4'h0;
  logic [3:0] utx_tlast = 4'h0;
  logic [255:0] utx_tdata = 256'h0;
  logic [127:0] utx_tuser = 128'h0;
  logic [15:0] dev = 16'h0;
  logic [31:0] wv[8];
  logic [3:0] ft_tab[10] = '{4'h2, 4'h5, 4'h6, 4'ha, 4'hd, 4'h8, 4'hb, 4'h0, 4'h3, 4'hf};
  int n_checks = 0;
  int bad_count = 0;
  logic [109:0] exp_rx[$];
  logic [104:0] exp_tx[$];
  logic [1:0] order[$];
  wire ucfg_ready, ucfg_rvalid, rx_v, rx_r, rx_l, tx_v, tx_r, tx_l, urx_tlast;
  wire [1:0] cfg_wr, cfg_rd;
  wire [3:0] utx_tready;
  wire [4:0] urx_tvalid;
  wire [7:0] tx_k, urx_tkeep;
  wire [15:0] cfg_addr;
  wire [31:0] reg_rdata, ucfg_rdata, tx_u, urx_tuser, lk_rd, bf_rd;
  wire [63:0] cfg_wdata, rx_d, tx_d, urx_tdata;
  wire [109:0] urx_all = {urx_tvalid, urx_tlast, urx_tdata, urx_tkeep, urx_tuser};
  wire [104:0] tx_all = {tx_l, tx_d, tx_u, tx_k};
  tpr_router dut (
    .core_clk,
    .rst_n,
    .cfg_rst_n,
    .reg_addr,
    .reg_wdata,
    .reg_wr,
    .reg_rd,
    .reg_rdata,
    .ucfg_valid,
    .ucfg_wr,
    .ucfg_addr,
    .ucfg_wdata,
    .ucfg_ready,
    .ucfg_rvalid,
    .ucfg_rdata,
    .link_cfg_wr(cfg_wr[0]),
    .link_cfg_rd(cfg_rd[0]),
    .link_cfg_addr(cfg_addr[7:0]),
    .link_cfg_wdata(cfg_wdata[31:0]),
    .link_cfg_rdata(lk_rd),
    .buf_cfg_wr(cfg_wr[1]),
    .buf_cfg_rd(cfg_rd[1]),
    .buf_cfg_addr(cfg_addr[15:8]),
    .buf_cfg_wdata(cfg_wdata[63:32]),
    .buf_cfg_rdata(bf_rd),
    .trn_rx_tvalid(rx_v),
    .trn_rx_tready(rx_r),
    .trn_rx_tdata(rx_d),
    .trn_rx_tkeep(8'hff),
    .trn_rx_tlast(rx_l),
    .trn_rx_tuser(32'h0),
    .trn_tx_tvalid(tx_v),
    .trn_tx_tready(tx_r),
    .trn_tx_tdata(tx_d),
    .trn_tx_tkeep(tx_k),
    .trn_tx_tlast(tx_l),
    .trn_tx_tuser(tx_u),
    .urx_tvalid,
    .urx_tready,
    .urx_tdata,
    .urx_tkeep,
    .urx_tlast,
    .urx_tuser,
    .utx_tvalid,
    .utx_tready,
    .utx_tdata,
    .utx_tkeep(32'hffffffff),
    .utx_tlast,
    .utx_tuser
  );
  tpr_link_model lnk (
    .core_clk,
    .rx_tvalid(rx_v),
    .rx_tready(rx_r),
    .rx_tdata(rx_d),
    .rx_tlast(rx_l),
    .tx_tready(tx_r),
    .cfg_wr,
    .cfg_rd,
    .cfg_addr,
    .cfg_wdata,
    .cfg_rdata({bf_rd, lk_rd})
  );
  always #20 core_clk = ~core_clk;
  // ****************************************
  // checkers and tasks
  // ****************************************
  always @(posedge core_clk) begin
    if (rst_n) begin
      urx_tready <= 5'($urandom);
      if (|(urx_tvalid & urx_tready)) begin
        `CHK(urx_all, exp_rx[0])
        void'(exp_rx.pop_front());
      end
      if (tx_v && tx_r) begin
        `CHK(tx_all, exp_tx[0])
        void'(exp_tx.pop_front());
      end
    end
  end
  function automatic logic [2:0] dst_of(input logic [3:0] ft);
    case (ft)
      `TPR_FT_NREAD, `TPR_FT_NWRITE, `TPR_FT_SWRITE, `TPR_FT_RESP: return 3'h0;
      `TPR_FT_DBELL: return 3'h0;
      `TPR_FT_MSG: return 3'h2;
      `TPR_FT_MAINT: return 3'h3;
      default: return 3'h4;
    endcase
  endfunction
  task automatic acc(input bit w, input logic [11:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    @(posedge core_clk);
    if (!w) `CHK(reg_rdata, d)
  endtask
  task automatic ucfg(input bit w, input logic [11:0] a, input logic [31:0] d);
    ucfg_valid <= 1'h1;
    ucfg_wr <= w;
    ucfg_addr <= a;
    ucfg_wdata <= d;
    do @(posedge core_clk); while (ucfg_ready !== 1'h1);
    ucfg_valid <= 1'h0;
    @(posedge core_clk);
    if (!w) `CHK({ucfg_rvalid, ucfg_rdata}, {1'h1, d})
  endtask
  // header format: every beat keeps all bytes
  task automatic rxp(input logic [3:0] ft, input int n);
    logic [63:0] x;
    for (int i = 0; i < n; i++) begin
      x = {$urandom, $urandom};
      if (i == 0) x[55:52] = ft;
      lnk.push(x, i == n - 1);
      exp_rx.push_back({5'h1 << dst_of(ft), i == n - 1, x, 8'hff, 32'h0});
    end
  endtask
  // later beats already carry the id, so either reading of the id swap holds
  task automatic txp(input int s, input int n);
    logic [63:0] x;
    logic [31:0] u;
    for (int i = 0; i < n; i++) begin
      x = {$urandom, $urandom};
      u = $urandom;
      if (i != 0) u[31:16] = dev;
      utx_tvalid[s] <= 1'h1;
      utx_tdata[64*s+:64] <= x;
      utx_tuser[32*s+:32] <= u;
      utx_tlast[s] <= i == n - 1;
      do @(posedge core_clk); while (utx_tready[s] !== 1'h1);
      exp_tx.push_back({i == n - 1, x, dev, u[15:0], 8'hff});
      order.push_back(2'(s));
    end
    utx_tvalid[s] <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(32'h2294));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'h1;
    cfg_rst_n <= 1'h1;
    @(posedge core_clk);
    acc(0, 12'h000, 32'h3);
    acc(0, 12'h004, 32'h60);
    acc(0, 12'h008, 32'h0);
    acc(0, 12'h00c, 32'h0);
    acc(1, 12'hc0c, 32'hffffffff);
    acc(0, 12'hc0c, 32'h0);
    acc(0, 12'h30c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wv[i] = $urandom;
      acc(1, 12'(256 + 256 * (i % 2) + 4 * (i / 2)), wv[i]);
    end
    for (int i = 0; i < 8; i++) acc(0, 12'(256 + 256 * (i % 2) + 4 * (i / 2)), wv[i]);
    acc(1, 12'h000, 32'h0);
    acc(1, 12'h00c, 32'hbeef);
    acc(0, 12'h00c, 32'hbeef);
    cfg_rst_n <= 1'h0;
    @(posedge core_clk);
    cfg_rst_n <= 1'h1;
    @(posedge core_clk);
    acc(0, 12'h000, 32'h3);
    acc(0, 12'h00c, 32'h0);
    $display("test registers done");
    dev = 16'($urandom);
    acc(1, 12'h00c, {16'hffff, dev});
    acc(0, 12'h00c, {16'h0, dev});
    ucfg(0, 12'h00c, {16'h0, dev});
    ucfg(1, 12'h2f0, 32'h5a5a0f0f);
    acc(0, 12'h2f0, 32'h5a5a0f0f);
    ucfg(1, 12'h1f0, 32'h0ff0c33c);
    ucfg(0, 12'h1f0, 32'h0ff0c33c);
    $display("test user config done");
    foreach (ft_tab[i]) rxp(ft_tab[i], $urandom_range(1, 4));
    repeat (24) rxp(4'($urandom), $urandom_range(1, 3));
    for (int k = 0; k < 3000 && exp_rx.size() != 0; k++) @(posedge core_clk);
    `CHK(exp_rx.size(), 0)
    acc(0, 12'h008, 32'h0);
    $display("test receive done");
    for (int s = 0; s < 4; s++) txp(s, $urandom_range(1, 3));
    order.delete();
    fork
      txp(3, 2);
      txp(0, 2);
    join
    for (int k = 0; k < 500 && exp_tx.size() != 0; k++) @(posedge core_clk);
    `CHK({order[0], order[1]}, 4'h0)
    `CHK(exp_tx.size(), 0)
    $display("test transmit done");
    conclude();
  end
endmodule
